// file: design/capture_compare_timer_unit.sv
`timescale 1ns/1ns
module capture_compare_timer_unit (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [31:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire logic        capture_input_0_i,
	input  wire logic        external_count_input_i,
	input  wire logic        external_clear_input_i,
	input  wire logic        fault_input_i,
	input  wire logic        fault_edge_low_i,
	input  wire logic        fault_edge_high_i,
	input  wire logic        shared_port_bit_i,
	output logic             shared_port_bit_o,
	output logic             shared_port_bit_oe_n_o,
	output logic             overflow_interrupt_o,
	output logic             channel0_interrupt_o,
	output logic             channel1_interrupt_o
);
	// bus group state
	logic        wait_r, wait_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [7:0]  tc1_r, tc1_nxt;
	logic [7:0]  esel_r, esel_nxt;
	logic [3:0]  port_r, port_nxt;
	logic        ose_r, ose_nxt;
	// timer group state
	cct_pkg::count_state_t state_r, state_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [15:0] cc_r [2];
	logic [15:0] cc_nxt [2];
	logic        ce_r, ce_nxt;
	logic        ovf_r, ovf_nxt;
	logic        act_r, act_nxt;
	logic        stop_r, stop_nxt;
	logic [2:0]  irq_r, irq_nxt;
	logic        pin_r, pin_nxt;
	logic        oe_n_r, oe_n_nxt;
	// decode and edge signals
	logic        wr_go;
	logic        wr_tc0, wr_cc0, wr_cc1;
	logic [cct_pkg::NUM_EDGES-1:0]   sig_v;
	logic [cct_pkg::NUM_EDGES-1:0]   edge_v;
	logic [2*cct_pkg::NUM_EDGES-1:0] sel_v;
	logic        cap1_mode, tout_mode;

	// merge byte lanes 0 and 1 into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = d[7:0];
		end
		if (be[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction : merge16

	// pin role decode
	assign cap1_mode = port_r[cct_pkg::PORT_MODE_CONTROL] & ~port_r[cct_pkg::PORT_FUNCTION];
	assign tout_mode = port_r[cct_pkg::PORT_MODE_CONTROL] & port_r[cct_pkg::PORT_FUNCTION];

	// edge detector inputs and their codes; the pin only feeds channel 1 in capture-input role
	assign sig_v = {fault_input_i, external_clear_input_i, external_count_input_i,
	                shared_port_bit_i & cap1_mode, capture_input_0_i};
	assign sel_v = {fault_edge_high_i, fault_edge_low_i,
	                esel_r[cct_pkg::ESEL_CLEAR+:2], esel_r[cct_pkg::ESEL_COUNT+:2],
	                esel_r[cct_pkg::ESEL_CAPTURE1+:2], esel_r[cct_pkg::ESEL_CAPTURE0+:2]};

	// one detector per edge source
	for (genvar g = 0; g < cct_pkg::NUM_EDGES; g++) begin : g_edge
		edge_detect u_edge (
			.clk_i     (clk_i),
			.sys_rst_i (sys_rst_i),
			.sig_i     (sig_v[g]),
			.sel_i     (sel_v[2*g+:2]),
			.edge_o    (edge_v[g])
		);
	end

	// a write takes effect at the edge where waitrequest is seen low
	assign wr_go  = avs_write_i & ~wait_r;
	assign wr_tc0 = wr_go & avs_byteenable_i[0] & (avs_address_i == cct_pkg::ADDR_TIMER_CONTROL_0);
	assign wr_cc0 = wr_go & (avs_address_i == cct_pkg::ADDR_CHANNEL0_CC);
	assign wr_cc1 = wr_go & (avs_address_i == cct_pkg::ADDR_CHANNEL1_CC);

	// bus slave: one wait cycle per access, read data captured on the first cycle
	always_comb begin
		wait_nxt  = ~((avs_read_i | avs_write_i) & wait_r);
		rdata_nxt = rdata_r;
		tc1_nxt   = tc1_r;
		esel_nxt  = esel_r;
		port_nxt  = port_r;
		ose_nxt   = ose_r;
		if (avs_read_i & wait_r) begin
			case (avs_address_i)
				cct_pkg::ADDR_TIMER_CONTROL_0: rdata_nxt = {29'h0, state_r == cct_pkg::ST_HALT, ovf_r, ce_r};
				cct_pkg::ADDR_TIMER_CONTROL_1: rdata_nxt = {24'h0, tc1_r};
				cct_pkg::ADDR_EDGE_SELECT:     rdata_nxt = {24'h0, esel_r};
				cct_pkg::ADDR_MAIN_COUNTER:    rdata_nxt = {16'h0, cnt_r};
				cct_pkg::ADDR_CHANNEL0_CC:     rdata_nxt = {16'h0, cc_r[0]};
				cct_pkg::ADDR_CHANNEL1_CC:     rdata_nxt = {16'h0, cc_r[1]};
				cct_pkg::ADDR_PORT_CONTROL:    rdata_nxt = {27'h0, shared_port_bit_i, port_r};
				cct_pkg::ADDR_OUTPUT_STOP_CTRL: rdata_nxt = {31'h0, ose_r};
				default:                       rdata_nxt = 32'h0;
			endcase
		end
		if (wr_go & avs_byteenable_i[0]) begin
			case (avs_address_i)
				cct_pkg::ADDR_TIMER_CONTROL_1:  tc1_nxt  = avs_writedata_i[7:0];
				cct_pkg::ADDR_EDGE_SELECT:      esel_nxt = avs_writedata_i[7:0];
				cct_pkg::ADDR_PORT_CONTROL:     port_nxt = avs_writedata_i[3:0];
				cct_pkg::ADDR_OUTPUT_STOP_CTRL: ose_nxt  = avs_writedata_i[cct_pkg::OSC_STOP_ENABLE];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h0;
			tc1_r   <= cct_pkg::RST_TC1;
			esel_r  <= cct_pkg::RST_EDGE_SEL;
			port_r  <= cct_pkg::RST_PORT;
			ose_r   <= 1'b0;
		end else begin
			wait_r  <= wait_nxt;
			rdata_r <= rdata_nxt;
			tc1_r   <= tc1_nxt;
			esel_r  <= esel_nxt;
			port_r  <= port_nxt;
			ose_r   <= ose_nxt;
		end
	end

	// timer core: counter, channels, flags, interrupts, pin
	always_comb begin
		logic        tick;
		logic        mclr;
		logic        wrap;
		logic [15:0] nv;
		logic [1:0]  match;
		logic        lvl;
		tick      = 1'b0;
		mclr      = 1'b0;
		wrap      = 1'b0;
		nv        = cnt_r;
		match     = 2'b00;
		lvl       = 1'b0;
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		ce_nxt    = ce_r;
		ovf_nxt   = ovf_r;
		act_nxt   = act_r;
		irq_nxt   = 3'b000;
		cc_nxt[0] = wr_cc0 ? merge16(cc_r[0], avs_writedata_i, avs_byteenable_i) : cc_r[0];
		cc_nxt[1] = wr_cc1 ? merge16(cc_r[1], avs_writedata_i, avs_byteenable_i) : cc_r[1];
		if (wr_tc0) begin
			ce_nxt  = avs_writedata_i[cct_pkg::TC0_COUNT_ENABLE];
			ovf_nxt = avs_writedata_i[cct_pkg::TC0_OVERFLOW_FLAG];
		end
		// free run steps every clock, event mode only on a valid count edge
		tick = tc1_r[cct_pkg::TC1_EVENT_COUNT] ? edge_v[cct_pkg::EDGE_COUNT] : 1'b1;
		// channel 0 match clear has priority over the natural wrap
		mclr = tc1_r[cct_pkg::TC1_CH0_MODE] & tc1_r[cct_pkg::TC1_MATCH_CLEAR] & (cnt_r == cc_r[0]);
		wrap = (cnt_r == cct_pkg::COUNT_MAX) & ~mclr;
		nv   = mclr ? cct_pkg::RST_COUNTER : cnt_r + 16'h0001;
		case (state_r)
			cct_pkg::ST_IDLE: begin
				if (wr_tc0 & avs_writedata_i[cct_pkg::TC0_COUNT_ENABLE]) begin
					state_nxt = cct_pkg::ST_RUN;
				end
			end
			cct_pkg::ST_RUN: begin
				if (wr_tc0 & ~avs_writedata_i[cct_pkg::TC0_COUNT_ENABLE]) begin
					state_nxt = cct_pkg::ST_IDLE;
					cnt_nxt   = cct_pkg::RST_COUNTER;
				end else if (tc1_r[cct_pkg::TC1_EXT_CLEAR_EN] & edge_v[cct_pkg::EDGE_CLEAR]) begin
					cnt_nxt = cct_pkg::RST_COUNTER;
				end else if (tick) begin
					// a write of 1 here changes nothing in the count
					cnt_nxt = nv;
					if (wrap) begin
						ovf_nxt    = 1'b1;
						irq_nxt[0] = 1'b1;
						if (tc1_r[cct_pkg::TC1_STOP_AFTER_OV]) begin
							state_nxt = cct_pkg::ST_HALT;
						end
					end
					// zero only counts as a match right after a wrap
					for (int n = 0; n < 2; n++) begin
						match[n] = tc1_r[cct_pkg::TC1_CH0_MODE+n] & (nv == cc_r[n]) & ((nv != 16'h0000) | wrap);
					end
				end
			end
			cct_pkg::ST_HALT: begin
				if (wr_tc0) begin
					cnt_nxt   = cct_pkg::RST_COUNTER;
					state_nxt = avs_writedata_i[cct_pkg::TC0_COUNT_ENABLE] ? cct_pkg::ST_RUN : cct_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = cct_pkg::ST_IDLE;
				cnt_nxt   = cct_pkg::RST_COUNTER;
			end
		endcase
		// capture: latch count on a valid edge, hardware wins over a same-cycle write
		for (int n = 0; n < 2; n++) begin
			if (~tc1_r[cct_pkg::TC1_CH0_MODE+n] & edge_v[cct_pkg::EDGE_CAP0+n]) begin
				cc_nxt[n] = cnt_r;
				irq_nxt[n+1] = 1'b1;
			end
			if (match[n]) begin
				irq_nxt[n+1] = 1'b1;
			end
		end
		// channel 0 sets the active level, channel 1 resets it; equal values stay inactive
		if (match[0]) begin
			act_nxt = 1'b1;
		end
		if (match[1]) begin
			act_nxt = 1'b0;
		end
		lvl = tc1_r[cct_pkg::TC1_PULSE_ENABLE] ? (act_nxt ~^ tc1_r[cct_pkg::TC1_ACTIVE_LEVEL])
		                                       : ~tc1_r[cct_pkg::TC1_ACTIVE_LEVEL];
		lvl = tc1_r[cct_pkg::TC1_PULSE_ENABLE] ? (act_nxt ? tc1_r[cct_pkg::TC1_ACTIVE_LEVEL]
		                                                   : ~tc1_r[cct_pkg::TC1_ACTIVE_LEVEL]) : lvl;
		// fault stop: only armed in timer output mode, cancelled while enable is 0
		if (~ose_r) begin
			stop_nxt = 1'b0;
		end else begin
			stop_nxt = stop_r | (tout_mode & edge_v[cct_pkg::EDGE_FAULT]);
		end
		// pin drive per role
		if (~port_r[cct_pkg::PORT_MODE_CONTROL]) begin
			pin_nxt  = port_r[cct_pkg::PORT_LATCH];
			oe_n_nxt = port_r[cct_pkg::PORT_DIRECTION];
		end else if (~port_r[cct_pkg::PORT_FUNCTION]) begin
			pin_nxt  = 1'b0;
			oe_n_nxt = 1'b1;
		end else begin
			pin_nxt  = lvl;
			oe_n_nxt = stop_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_r <= cct_pkg::ST_IDLE;
			cnt_r   <= cct_pkg::RST_COUNTER;
			cc_r[0] <= cct_pkg::RST_CC;
			cc_r[1] <= cct_pkg::RST_CC;
			ce_r    <= 1'b0;
			ovf_r   <= 1'b0;
			act_r   <= 1'b0;
			stop_r  <= 1'b0;
			irq_r   <= 3'b000;
			pin_r   <= 1'b0;
			oe_n_r  <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			cc_r[0] <= cc_nxt[0];
			cc_r[1] <= cc_nxt[1];
			ce_r    <= ce_nxt;
			ovf_r   <= ovf_nxt;
			act_r   <= act_nxt;
			stop_r  <= stop_nxt;
			irq_r   <= irq_nxt;
			pin_r   <= pin_nxt;
			oe_n_r  <= oe_n_nxt;
		end
	end

	// outputs straight from flops
	assign avs_readdata_o         = rdata_r;
	assign avs_waitrequest_o      = wait_r;
	assign shared_port_bit_o      = pin_r;
	assign shared_port_bit_oe_n_o = oe_n_r;
	assign overflow_interrupt_o   = irq_r[0];
	assign channel0_interrupt_o   = irq_r[1];
	assign channel1_interrupt_o   = irq_r[2];
endmodule : capture_compare_timer_unit

// file: design/edge_detect.sv
`timescale 1ns/1ns
// one input, one 2-bit edge code, a one-cycle valid-edge pulse
module edge_detect (
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       sig_i,
	input  wire logic [1:0] sel_i,
	output logic            edge_o
);
	logic prev_r;
	logic prev_nxt;

	// previous sample; inputs are already synchronous to clk_i
	always_comb begin
		prev_nxt = sig_i;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= prev_nxt;
		end
	end

	// code 10 matches no case item and never fires
	always_comb begin
		case (sel_i)
			cct_pkg::EDGE_FALLING: edge_o = prev_r & ~sig_i;
			cct_pkg::EDGE_RISING:  edge_o = ~prev_r & sig_i;
			cct_pkg::EDGE_BOTH:    edge_o = prev_r ^ sig_i;
			default:               edge_o = 1'b0;
		endcase
	end
endmodule : edge_detect

// file: shared/cct_pkg.sv
package cct_pkg;
	// register byte addresses
	localparam logic [31:0] ADDR_TIMER_CONTROL_0   = 32'hfffff600;
	localparam logic [31:0] ADDR_TIMER_CONTROL_1   = 32'hfffff604;
	localparam logic [31:0] ADDR_EDGE_SELECT       = 32'hfffff608;
	localparam logic [31:0] ADDR_MAIN_COUNTER      = 32'hfffff60c;
	localparam logic [31:0] ADDR_CHANNEL0_CC       = 32'hfffff610;
	localparam logic [31:0] ADDR_CHANNEL1_CC       = 32'hfffff614;
	localparam logic [31:0] ADDR_PORT_CONTROL      = 32'hfffff618;
	localparam logic [31:0] ADDR_OUTPUT_STOP_CTRL  = 32'hfffff6a0;
	// timer_control_0 fields
	localparam int TC0_COUNT_ENABLE  = 0;
	localparam int TC0_OVERFLOW_FLAG = 1;
	localparam int TC0_HALTED        = 2;
	// timer_control_1 fields
	localparam int TC1_CH0_MODE      = 0;
	localparam int TC1_CH1_MODE      = 1;
	localparam int TC1_EXT_CLEAR_EN  = 2;
	localparam int TC1_MATCH_CLEAR   = 3;
	localparam int TC1_EVENT_COUNT   = 4;
	localparam int TC1_ACTIVE_LEVEL  = 5;
	localparam int TC1_PULSE_ENABLE  = 6;
	localparam int TC1_STOP_AFTER_OV = 7;
	// edge select field positions (low bit of each 2-bit field)
	localparam int ESEL_CAPTURE0 = 0;
	localparam int ESEL_CAPTURE1 = 2;
	localparam int ESEL_CLEAR    = 4;
	localparam int ESEL_COUNT    = 6;
	// port control fields
	localparam int PORT_MODE_CONTROL = 0;
	localparam int PORT_FUNCTION     = 1;
	localparam int PORT_DIRECTION    = 2;
	localparam int PORT_LATCH        = 3;
	localparam int PORT_PIN_LEVEL    = 4;
	// output_stop_control fields
	localparam int OSC_STOP_ENABLE = 0;
	// edge codes
	localparam logic [1:0] EDGE_FALLING = 2'h0;
	localparam logic [1:0] EDGE_RISING  = 2'h1;
	localparam logic [1:0] EDGE_BOTH    = 2'h3;
	// reset values and counter maximum
	localparam logic [7:0]  RST_TC1        = 8'h00;
	localparam logic [7:0]  RST_EDGE_SEL   = 8'h00;
	localparam logic [3:0]  RST_PORT       = 4'h0;
	localparam logic [15:0] RST_CC         = 16'h0000;
	localparam logic [15:0] RST_COUNTER    = 16'h0000;
	localparam logic [15:0] COUNT_MAX      = 16'hffff;
	// edge detector slots
	localparam int NUM_EDGES   = 5;
	localparam int EDGE_CAP0   = 0;
	localparam int EDGE_CAP1   = 1;
	localparam int EDGE_COUNT  = 2;
	localparam int EDGE_CLEAR  = 3;
	localparam int EDGE_FAULT  = 4;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_RUN  = 3'h2,
		ST_HALT = 3'h4
	} count_state_t;
endpackage : cct_pkg

// file: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
	localparam logic [31:0] a_tc0  = cct_pkg::ADDR_TIMER_CONTROL_0;
	localparam logic [31:0] a_tc1  = cct_pkg::ADDR_TIMER_CONTROL_1;
	localparam logic [31:0] a_esel = cct_pkg::ADDR_EDGE_SELECT;
	localparam logic [31:0] a_cnt  = cct_pkg::ADDR_MAIN_COUNTER;
	localparam logic [31:0] a_cc0  = cct_pkg::ADDR_CHANNEL0_CC;
	localparam logic [31:0] a_cc1  = cct_pkg::ADDR_CHANNEL1_CC;
	localparam logic [31:0] a_port = cct_pkg::ADDR_PORT_CONTROL;
	localparam logic [31:0] a_osc  = cct_pkg::ADDR_OUTPUT_STOP_CTRL;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [31:0] address = 32'h0;
	logic        rd_en = 1'b0;
	logic        wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic        waitreq;
	logic [4:0]  flip = 5'h00;
	logic [3:0]  be = 4'h3;
	logic [1:0]  fcode = cct_pkg::EDGE_RISING;
	logic [4:0]  line;
	logic        pad;
	logic        pin_drv;
	logic        pin_oe_n;
	logic        edge_low;
	logic        edge_high;
	logic [2:0]  irq;
	logic [31:0] rd_val;
	logic [63:0] rq[$];
	logic [2:0]  iq[$];
	logic [1:0]  codes [4] = '{cct_pkg::EDGE_RISING, cct_pkg::EDGE_BOTH, cct_pkg::EDGE_FALLING, 2'h2};
	logic [3:0]  hits [4] = '{4'h5, 4'hf, 4'ha, 4'h0};
	logic [7:0]  ports [4] = '{8'h08, 8'h00, 8'h04, 8'h01};
	logic [1:0]  pins [4] = '{2'h1, 2'h0, 2'h2, 2'h2};
	int          err_total = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          t_flip = 0;
	// 20 MHz, plus a cycle count for edge spacing
	always #25 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	capture_compare_timer_unit dut_u (.clk_i(clk), .sys_rst_i(sys_rst), .avs_address_i(address),
		.avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(be),
		.avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .capture_input_0_i(line[0]),
		.external_count_input_i(line[2]), .external_clear_input_i(line[3]), .fault_input_i(line[4]),
		.fault_edge_low_i(edge_low), .fault_edge_high_i(edge_high), .shared_port_bit_i(pad),
		.shared_port_bit_o(pin_drv), .shared_port_bit_oe_n_o(pin_oe_n), .overflow_interrupt_o(irq[2]),
		.channel1_interrupt_o(irq[1]), .channel0_interrupt_o(irq[0]));
	trigger_source far_u (.clk_i(clk), .rst_i(sys_rst), .flip_i(flip), .fcode_i(fcode), .pin_drv_i(pin_drv),
		.pin_oe_n_i(pin_oe_n), .line_o(line), .pad_o(pad), .edge_low_o(edge_low), .edge_high_o(edge_high));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic hang();
		err_total++;
		$display("CHECK FAILED at %0t: wait ran out", $time);
		print_verdict();
	endtask : hang
	task automatic cmp_val(input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_val
	task automatic cmp_irq(input logic [2:0] exp, input logic [2:0] got);
		cmp_val({29'h0, exp}, {29'h0, got});
	endtask : cmp_irq
	// request held until waitrequest is sampled low, released at that edge
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		wr_en <= w;
		rd_en <= !w;
		wdata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		if (waitreq !== 1'b0) hang();
		rd_val = rdata;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] mask);
		rq.push_back({exp, mask});
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic flip_line(input int b);
		@(posedge clk);
		flip <= 5'(1 << b);
		t_flip = cyc;
		@(posedge clk);
		flip <= 5'h00;
	endtask : flip_line
	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (irq === 3'h0 && n < lim);
		if (irq === 3'h0) hang();
	endtask : wait_irq
	// oldest note against each read answer and each interrupt pulse
	always @(posedge clk) begin
		logic [63:0] e;
		if (rd_en && waitreq === 1'b0) begin
			e = rq.pop_front();
			cmp_val(e[63:32] & e[31:0], rdata & e[31:0]);
		end
		if (irq !== 3'h0) cmp_irq(iq.size() > 0 ? iq.pop_front() : 3'h0, irq);
	end
	initial begin
		int p;
		int first;
		logic [15:0] base;
		logic [15:0] k;
		p = $urandom(99);
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		// reset values, stop register access, unmapped place
		rd(a_tc0, 32'h0, 32'hff);
		rd(a_tc1, 32'h0, 32'hff);
		rd(a_osc, 32'h0, 32'hff);
		wr(32'hfffff7f0, 32'hffff);
		rd(32'hfffff7f0, 32'h0, 32'hffffffff);
		wr(a_osc, 32'h1);
		rd(a_osc, 32'h1, 32'hff);
		wr(a_osc, 32'h0);
		// every edge code; latched values must differ by the edge spacing
		for (int c = 0; c < 4; c++) begin
			wr(a_tc0, 32'h0);
			rd(a_cnt, 32'h0, 32'hffff);
			wr(a_esel, {30'h0, codes[c]});
			wr(a_tc0, 32'h1);
			first = -1;
			for (int j = 0; j < 4; j++) begin
				if (hits[c][j]) iq.push_back(3'h1);
				flip_line(0);
				repeat (3 + $urandom % 30) @(posedge clk);
				if (hits[c][j] && first < 0) begin
					rd(a_cc0, 32'h0, 32'h0);
					first = t_flip;
					base = rd_val[15:0];
				end else if (hits[c][j]) begin
					rd(a_cc0, {16'h0, base + 16'(t_flip - first)}, 32'hffff);
				end
			end
		end
		// lane 1 only: the low byte of the channel register must keep its value
		be <= 4'h2;
		wr(a_cc1, 32'habcd);
		be <= 4'h3;
		rd(a_cc1, 32'hab00, 32'hffff);
		// wrap with ch1 comparing at 0000 and stop after overflow
		wr(a_tc0, 32'h0);
		wr(a_tc1, 32'h82);
		wr(a_cc1, 32'h0);
		iq.push_back(3'h6);
		wr(a_tc0, 32'h1);
		wait_irq(70000);
		rd(a_tc0, 32'h6, 32'h6);
		repeat (20) @(posedge clk);
		rd(a_cnt, 32'h0, 32'hffff);
		// interval on ch0 with match clear, timer output on the pad
		k = 16'(20 + $urandom % 80);
		wr(a_tc0, 32'h0);
		wr(a_port, 32'h3);
		wr(a_tc1, 32'h69);
		wr(a_cc0, {16'h0, k});
		iq.push_back(3'h1);
		iq.push_back(3'h1);
		wr(a_tc0, 32'h1);
		wait_irq(200);
		cmp_val(32'h1, {30'h0, pin_oe_n, pad});
		p = cyc;
		wr(a_tc0, 32'h1);
		wait_irq(200);
		cmp_val(32'(k) + 32'h1, 32'(cyc - p));
		wr(a_tc0, 32'h0);
		// fault edge releases the pad only while output stop is enabled
		wr(a_osc, 32'h1);
		flip_line(4);
		repeat (4) @(posedge clk);
		cmp_val(32'h2, {30'h0, pin_oe_n, pad});
		wr(a_osc, 32'h0);
		repeat (3) @(posedge clk);
		cmp_val(32'h1, {30'h0, pin_oe_n, pad});
		fcode <= cct_pkg::EDGE_BOTH;
		flip_line(4);
		flip_line(4);
		repeat (4) @(posedge clk);
		cmp_val(32'h1, {30'h0, pin_oe_n, pad});
		// port roles: latch out, input, ch1 capture through the pad
		for (int j = 0; j < 4; j++) begin
			wr(a_port, {24'h0, ports[j]});
			repeat (3) @(posedge clk);
			cmp_val({30'h0, pins[j]}, {30'h0, pin_oe_n, pad});
		end
		wr(a_esel, 32'h4);
		iq.push_back(3'h2);
		flip_line(1);
		wait_irq(20);
		// event counting on the count line, cleared on a falling clear line edge
		wr(a_tc1, 32'h15);
		wr(a_esel, 32'h40);
		wr(a_tc0, 32'h1);
		k = 16'(2 + $urandom % 5);
		repeat (k) begin
			flip_line(2);
			flip_line(2);
		end
		flip_line(3);
		rd(a_cnt, {16'h0, k}, 32'hffff);
		flip_line(3);
		rd(a_cnt, 32'h0, 32'hffff);
		wr(a_tc0, 32'h0);
		repeat (2) @(posedge clk);
		cmp_val(32'h0, 32'(iq.size()));
		print_verdict();
	end
endmodule : testbench

// file: sim/timer_unit_checker.sv
`timescale 1ns/1ns
// bus handshake, interrupt pulses and pad drive of the timer
module timer_unit_checker (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire logic        fault_input_i,
	input wire logic        shared_port_bit_o,
	input wire logic        shared_port_bit_oe_n_o,
	input wire logic        overflow_interrupt_o,
	input wire logic        channel0_interrupt_o,
	input wire logic        channel1_interrupt_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// one event gives one cycle of request
	ovf_pulse_a: assert property (overflow_interrupt_o |=> !overflow_interrupt_o)
		else $error("overflow interrupt longer than one cycle");
	ch0_pulse_a: assert property (channel0_interrupt_o |=> !channel0_interrupt_o)
		else $error("channel 0 interrupt longer than one cycle");
	ch1_pulse_a: assert property (channel1_interrupt_o |=> !channel1_interrupt_o)
		else $error("channel 1 interrupt longer than one cycle");
	// a taken request is answered after one wait cycle, for one cycle
	bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("request not answered in one cycle");
	bus_release_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer held past one cycle");
	stray_answer_a: assert property (!avs_waitrequest_o |-> $past(avs_waitrequest_o) && $past(avs_read_i || avs_write_i))
		else $error("answer without a request");
	read_hold_a: assert property (!$stable(avs_readdata_o) |-> !avs_waitrequest_o && avs_read_i)
		else $error("read data moved outside a read answer");
	// pad level moves only on a compare match or after a config write
	pin_change_a: assert property (
		$changed(shared_port_bit_o) |-> channel0_interrupt_o || channel1_interrupt_o
		|| $past(avs_write_i) || $past(avs_write_i, 2) || $past(avs_write_i, 3))
		else $error("pad level changed without cause");
	// release needs a fault edge one or two cycles back or a write
	stop_release_a: assert property (
		$rose(shared_port_bit_oe_n_o) |-> $past(avs_write_i) || $past(avs_write_i, 2) || $past(avs_write_i, 3)
		|| $past(fault_input_i) != $past(fault_input_i, 2) || $past(fault_input_i, 2) != $past(fault_input_i, 3))
		else $error("pad released without a fault edge or a write");
endmodule : timer_unit_checker

bind capture_compare_timer_unit timer_unit_checker chk_u (.clk_i, .sys_rst_i, .avs_read_i, .avs_write_i,
	.avs_readdata_o, .avs_waitrequest_o, .fault_input_i, .shared_port_bit_o, .shared_port_bit_oe_n_o,
	.overflow_interrupt_o, .channel0_interrupt_o, .channel1_interrupt_o);

// file: sim/trigger_source.sv
`timescale 1ns/1ns
// far side: capture, count, clear and fault lines and the shared pad
module trigger_source (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [4:0] flip_i,
	input  wire logic [1:0] fcode_i,
	input  wire logic       pin_drv_i,
	input  wire logic       pin_oe_n_i,
	output logic      [4:0] line_o,
	output logic            pad_o,
	output logic            edge_low_o,
	output logic            edge_high_o
);
	// each request toggles its line once, right after an edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			line_o <= 5'h00;
		end else begin
			line_o <= line_o ^ flip_i;
		end
	end
	// fault edge code as the bench sets it; the bench moves it only with the timer stopped
	assign edge_low_o  = fcode_i[0];
	assign edge_high_o = fcode_i[1];
	// released pad follows our level; the design's drive wins when enabled
	assign pad_o = pin_oe_n_i ? line_o[1] : pin_drv_i;
endmodule : trigger_source
